// file: hdl/sftpr_top.sv
// Read-only timing parameter table behind an AXI4-Lite slave
//
// What this block does
// - Word ten bits 22:18 hold sector type 3 erase count 10000b.
// - Word ten bits 17:16 hold sector type 2 erase units 01b, 16 ms.
// - Word ten bits 15:11 hold sector type 2 erase count 01011b.
// - Word ten bits 10:9 hold sector type 1 erase units 01b, 16 ms.
// - Word ten bits 8:4 hold sector type 1 erase count 00010b.
// - Word ten bits 3:0 hold erase max multiplier count 0001b.
// - Word ten reads FE_C1_5A_21; byte FEh sits at relative 27h.
// - Word eleven bit 23, additional byte program units, is 0 (1 us).
// - Word eleven bits 22:19 hold additional byte program count 0101b.
// - Word eleven bit 18, first byte program units, is 0 (1 us).
// - Word eleven bits 17:14 hold first byte program count 0111b.
// - Word eleven bit 13, page program units, is 1 (64 us).
// - Word eleven bits 12:8 hold page program count 00100b.
// - Word eleven bits 7:4 hold page size exponent 1000b.
// - Word eleven bits 3:0 hold page program multiplier count 0001b.
// - Bytes 28h, 29h, 2Ah read 81h, E4h, 29h.
`default_nettype none
module sftpr_top (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  // Write address channel
  input wire logic I_S_AWVALID,
  input wire logic [sftpr_pkg::ADDR_W-1:0] I_S_AWADDR,
  input wire logic [2:0] I_S_AWPROT,
  output logic O_S_AWREADY,
  // Write data channel
  input wire logic I_S_WVALID,
  input wire logic [sftpr_pkg::DATA_W-1:0] I_S_WDATA,
  input wire logic [sftpr_pkg::STRB_W-1:0] I_S_WSTRB,
  output logic O_S_WREADY,
  // Write response channel
  output logic O_S_BVALID,
  output logic [1:0] O_S_BRESP,
  input wire logic I_S_BREADY,
  // Read address channel
  input wire logic I_S_ARVALID,
  input wire logic [sftpr_pkg::ADDR_W-1:0] I_S_ARADDR,
  input wire logic [2:0] I_S_ARPROT,
  output logic O_S_ARREADY,
  // Read data channel
  output logic O_S_RVALID,
  output logic [sftpr_pkg::DATA_W-1:0] O_S_RDATA,
  output logic [1:0] O_S_RRESP,
  input wire logic I_S_RREADY
);

  // ----------------------------------------------------------------
  // Address decoding shared by both directions
  // ----------------------------------------------------------------
  function automatic sftpr_pkg::sftpr_reg_t decode_reg(
    input logic [sftpr_pkg::ADDR_W-1:0] addr
  );
    logic [7:0] rel;
    rel = {2'h0, addr[sftpr_pkg::ADDR_W-1:sftpr_pkg::WORD_LSB]};
    if (addr[sftpr_pkg::WORD_LSB-1:0] != 2'h0)
      decode_reg = sftpr_pkg::REG_NONE;
    else if (addr == sftpr_pkg::ADDR_PTR)
      decode_reg = sftpr_pkg::REG_PTR;
    else if (addr == sftpr_pkg::ADDR_DATA)
      decode_reg = sftpr_pkg::REG_DATA;
    else if (addr == sftpr_pkg::ADDR_STAT)
      decode_reg = sftpr_pkg::REG_STAT;
    else if (rel >= sftpr_pkg::REL_FIRST && rel <= sftpr_pkg::REL_LAST)
      decode_reg = sftpr_pkg::REG_ROM;
    else
      decode_reg = sftpr_pkg::REG_NONE;
  endfunction

  // Relative table address carried by a byte-window address
  function automatic logic [7:0] rel_of(
    input logic [sftpr_pkg::ADDR_W-1:0] addr
  );
    rel_of = {2'h0, addr[sftpr_pkg::ADDR_W-1:sftpr_pkg::WORD_LSB]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [sftpr_pkg::DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_have_reg;
  logic [sftpr_pkg::ADDR_W-1:0] awaddr_reg;
  logic w_have_reg;
  logic [sftpr_pkg::DATA_W-1:0] wdata_reg;
  logic [sftpr_pkg::STRB_W-1:0] wstrb_reg;
  logic [7:0] ptr_reg;
  logic [sftpr_pkg::STAT_CNT_W-1:0] rej_cnt_reg;
  logic oor_reg;

  // Handshakes and the write that fires this cycle
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic b_hs;
  logic r_hs;
  logic wr_fire;
  logic [sftpr_pkg::ADDR_W-1:0] wr_addr;
  logic [sftpr_pkg::DATA_W-1:0] wr_data;
  logic [sftpr_pkg::STRB_W-1:0] wr_strb;
  sftpr_pkg::sftpr_reg_t wr_kind;
  sftpr_pkg::sftpr_reg_t rd_kind;
  logic ptr_wr;
  logic data_rd;
  logic rej_wr;

  // Lookup port of the table
  logic [7:0] rom_addr;
  logic [7:0] rom_byte;
  logic rom_hit;

  // ----------------------------------------------------------------
  // Handshake terms
  // ----------------------------------------------------------------
  assign aw_hs = I_S_AWVALID && awready_reg;
  assign w_hs = I_S_WVALID && wready_reg;
  assign ar_hs = I_S_ARVALID && arready_reg;
  assign b_hs = bvalid_reg && I_S_BREADY;
  assign r_hs = rvalid_reg && I_S_RREADY;

  // Write fires once address and data are both in hand
  assign wr_fire = (aw_have_reg || aw_hs) && (w_have_reg || w_hs) &&
                   !bvalid_reg;
  assign wr_addr = aw_have_reg ? awaddr_reg : I_S_AWADDR;
  assign wr_data = w_have_reg ? wdata_reg : I_S_WDATA;
  assign wr_strb = w_have_reg ? wstrb_reg : I_S_WSTRB;
  assign wr_kind = decode_reg(wr_addr);
  assign rd_kind = decode_reg(I_S_ARADDR);

  // Side effects of the current transfers
  assign ptr_wr = wr_fire && wr_kind == sftpr_pkg::REG_PTR && wr_strb[0];
  assign data_rd = ar_hs && rd_kind == sftpr_pkg::REG_DATA;
  assign rej_wr = wr_fire && wr_kind == sftpr_pkg::REG_ROM;

  // ----------------------------------------------------------------
  // Table lookup: window byte or the streaming pointer
  // ----------------------------------------------------------------
  assign rom_addr = (rd_kind == sftpr_pkg::REG_DATA) ? ptr_reg :
                    rel_of(I_S_ARADDR);

  sftpr_rom u_rom (
    .i_rel_addr(rom_addr),
    .o_byte(rom_byte),
    .o_hit(rom_hit)
  );

  // ----------------------------------------------------------------
  // Write address channel
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      awready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (b_hs)
    begin
      awready_reg <= 1'b1;
    end
    else if (aw_hs)
    begin
      awready_reg <= 1'b0;
      awaddr_reg <= I_S_AWADDR;
      aw_have_reg <= !wr_fire;
    end
    else if (wr_fire)
    begin
      aw_have_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write data channel
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      wready_reg <= 1'b1;
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else if (b_hs)
    begin
      wready_reg <= 1'b1;
    end
    else if (w_hs)
    begin
      wready_reg <= 1'b0;
      wdata_reg <= I_S_WDATA;
      wstrb_reg <= I_S_WSTRB;
      w_have_reg <= !wr_fire;
    end
    else if (wr_fire)
    begin
      w_have_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write response: table bytes refuse writes, holes decode-error
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= sftpr_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      unique case (wr_kind)
        sftpr_pkg::REG_PTR: bresp_reg <= sftpr_pkg::RESP_OKAY;
        sftpr_pkg::REG_DATA: bresp_reg <= sftpr_pkg::RESP_SLVERR;
        sftpr_pkg::REG_STAT: bresp_reg <= sftpr_pkg::RESP_SLVERR;
        sftpr_pkg::REG_ROM: bresp_reg <= sftpr_pkg::RESP_SLVERR;
        sftpr_pkg::REG_NONE: bresp_reg <= sftpr_pkg::RESP_DECERR;
      endcase
    end
    else if (b_hs)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Streaming pointer: write sets it, a data read steps it
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
      ptr_reg <= sftpr_pkg::PTR_RST;
    else if (ptr_wr)
      ptr_reg <= wr_data[7:0];
    else if (data_rd)
      ptr_reg <= ptr_reg + 8'h01;
  end

  // ----------------------------------------------------------------
  // Status: refused table writes and out-of-range stream reads
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
      rej_cnt_reg <= '0;
    else if (rej_wr && rej_cnt_reg != sftpr_pkg::CNT_MAX)
      rej_cnt_reg <= rej_cnt_reg + 16'h0001;
  end

  // Out-of-range flag follows the latest data read
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
      oor_reg <= 1'b0;
    else if (data_rd)
      oor_reg <= !rom_hit;
  end

  // ----------------------------------------------------------------
  // Read address channel
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
      arready_reg <= 1'b1;
    else if (ar_hs)
      arready_reg <= 1'b0;
    else if (r_hs)
      arready_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Read data channel: answer one cycle after the address
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= sftpr_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= '0;
      rresp_reg <= sftpr_pkg::RESP_OKAY;
      unique case (rd_kind)
        sftpr_pkg::REG_PTR:
          rdata_reg[7:0] <= ptr_reg;
        sftpr_pkg::REG_DATA:
          rdata_reg[7:0] <= rom_byte;
        sftpr_pkg::REG_STAT:
        begin
          rdata_reg[sftpr_pkg::STAT_CNT_W-1:0] <= rej_cnt_reg;
          rdata_reg[sftpr_pkg::STAT_OOR_BIT] <= oor_reg;
        end
        sftpr_pkg::REG_ROM:
          rdata_reg[7:0] <= rom_byte;
        sftpr_pkg::REG_NONE:
          rresp_reg <= sftpr_pkg::RESP_DECERR;
      endcase
    end
    else if (r_hs)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flip-flops
  // ----------------------------------------------------------------
  assign O_S_AWREADY = awready_reg;
  assign O_S_WREADY = wready_reg;
  assign O_S_BVALID = bvalid_reg;
  assign O_S_BRESP = bresp_reg;
  assign O_S_ARREADY = arready_reg;
  assign O_S_RVALID = rvalid_reg;
  assign O_S_RDATA = rdata_reg;
  assign O_S_RRESP = rresp_reg;

endmodule
`default_nettype wire

// file: hdl/sftpr_pkg.sv
// Constants for the timing parameter table and its register window
`default_nettype none
package sftpr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned BYTE_W = 8;

  // ----------------------------------------------------------------
  // Response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Register map: table bytes sit at four times their relative address
  // ----------------------------------------------------------------
  localparam logic [7:0] REL_FIRST = 8'h24;
  localparam logic [7:0] REL_LAST = 8'h2a;
  localparam logic [7:0] REL_W10 = 8'h24;
  localparam logic [7:0] REL_W11 = 8'h28;
  localparam logic [7:0] REL_W10_TOP = 8'h27;
  localparam logic [ADDR_W-1:0] ADDR_PTR = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
  localparam int unsigned WORD_LSB = 2;

  // Status layout and reset values
  localparam int unsigned STAT_CNT_W = 16;
  localparam int unsigned STAT_OOR_BIT = 16;
  localparam logic [7:0] PTR_RST = 8'h24;
  localparam logic [STAT_CNT_W-1:0] CNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Tenth parameter word fields: lsb, width, stored value
  // ----------------------------------------------------------------
  localparam int unsigned T4U_LSB = 30;
  localparam logic [1:0] T4U_VAL = 2'h3;
  localparam int unsigned T4C_LSB = 25;
  localparam logic [4:0] T4C_VAL = 5'h1f;
  localparam int unsigned T3U_LSB = 23;
  localparam logic [1:0] T3U_VAL = 2'h1;
  localparam int unsigned T3C_LSB = 18;
  localparam logic [4:0] T3C_VAL = 5'h10;
  localparam int unsigned T2U_LSB = 16;
  localparam logic [1:0] T2U_VAL = 2'h1;
  localparam int unsigned T2C_LSB = 11;
  localparam logic [4:0] T2C_VAL = 5'h0b;
  localparam int unsigned T1U_LSB = 9;
  localparam logic [1:0] T1U_VAL = 2'h1;
  localparam int unsigned T1C_LSB = 4;
  localparam logic [4:0] T1C_VAL = 5'h02;
  localparam int unsigned EMUL_LSB = 0;
  localparam logic [3:0] EMUL_VAL = 4'h1;

  // ----------------------------------------------------------------
  // Eleventh parameter word fields (low three bytes)
  // ----------------------------------------------------------------
  localparam int unsigned ABU_LSB = 23;
  localparam logic [0:0] ABU_VAL = 1'h0;
  localparam int unsigned ABC_LSB = 19;
  localparam logic [3:0] ABC_VAL = 4'h5;
  localparam int unsigned FBU_LSB = 18;
  localparam logic [0:0] FBU_VAL = 1'h0;
  localparam int unsigned FBC_LSB = 14;
  localparam logic [3:0] FBC_VAL = 4'h7;
  localparam int unsigned PPU_LSB = 13;
  localparam logic [0:0] PPU_VAL = 1'h1;
  localparam int unsigned PPC_LSB = 8;
  localparam logic [4:0] PPC_VAL = 5'h04;
  localparam int unsigned PGN_LSB = 4;
  localparam logic [3:0] PGN_VAL = 4'h8;
  localparam int unsigned PMUL_LSB = 0;
  localparam logic [3:0] PMUL_VAL = 4'h1;

  // Kinds of address the slave knows
  typedef enum logic [2:0] {
    REG_PTR,
    REG_DATA,
    REG_STAT,
    REG_ROM,
    REG_NONE
  } sftpr_reg_t;

endpackage
`default_nettype wire

// file: hdl/sftpr_rom.sv
// Byte lookup into the erase and program timing parameter words
`default_nettype none
module sftpr_rom (
  // Lookup request
  input wire logic [7:0] i_rel_addr,
  // Lookup answer
  output logic [7:0] o_byte,
  output logic o_hit
);

  logic [sftpr_pkg::DATA_W-1:0] word10;
  logic [sftpr_pkg::DATA_W-1:0] word11;
  logic [7:0] offs;

  // ----------------------------------------------------------------
  // Tenth word assembled from its fields
  // ----------------------------------------------------------------
  always_comb
  begin
    word10 = '0;
    word10[sftpr_pkg::T4U_LSB +: 2] = sftpr_pkg::T4U_VAL;
    word10[sftpr_pkg::T4C_LSB +: 5] = sftpr_pkg::T4C_VAL;
    word10[sftpr_pkg::T3U_LSB +: 2] = sftpr_pkg::T3U_VAL;
    word10[sftpr_pkg::T3C_LSB +: 5] = sftpr_pkg::T3C_VAL;
    word10[sftpr_pkg::T2U_LSB +: 2] = sftpr_pkg::T2U_VAL;
    word10[sftpr_pkg::T2C_LSB +: 5] = sftpr_pkg::T2C_VAL;
    word10[sftpr_pkg::T1U_LSB +: 2] = sftpr_pkg::T1U_VAL;
    word10[sftpr_pkg::T1C_LSB +: 5] = sftpr_pkg::T1C_VAL;
    word10[sftpr_pkg::EMUL_LSB +: 4] = sftpr_pkg::EMUL_VAL;
  end

  // ----------------------------------------------------------------
  // Eleventh word, low three bytes only
  // ----------------------------------------------------------------
  always_comb
  begin
    word11 = '0;
    word11[sftpr_pkg::ABU_LSB +: 1] = sftpr_pkg::ABU_VAL;
    word11[sftpr_pkg::ABC_LSB +: 4] = sftpr_pkg::ABC_VAL;
    word11[sftpr_pkg::FBU_LSB +: 1] = sftpr_pkg::FBU_VAL;
    word11[sftpr_pkg::FBC_LSB +: 4] = sftpr_pkg::FBC_VAL;
    word11[sftpr_pkg::PPU_LSB +: 1] = sftpr_pkg::PPU_VAL;
    word11[sftpr_pkg::PPC_LSB +: 5] = sftpr_pkg::PPC_VAL;
    word11[sftpr_pkg::PGN_LSB +: 4] = sftpr_pkg::PGN_VAL;
    word11[sftpr_pkg::PMUL_LSB +: 4] = sftpr_pkg::PMUL_VAL;
  end

  // ----------------------------------------------------------------
  // Little-endian byte pick; top byte of word ten lands at 27h
  // ----------------------------------------------------------------
  always_comb
  begin
    offs = 8'h00;
    o_byte = 8'h00;
    o_hit = 1'b0;
    if (i_rel_addr >= sftpr_pkg::REL_FIRST &&
        i_rel_addr < sftpr_pkg::REL_W11)
    begin
      offs = i_rel_addr - sftpr_pkg::REL_W10;
      o_byte = word10[offs[1:0]*8 +: 8];
      o_hit = 1'b1;
    end
    else if (i_rel_addr >= sftpr_pkg::REL_W11 &&
             i_rel_addr <= sftpr_pkg::REL_LAST)
    begin
      offs = i_rel_addr - sftpr_pkg::REL_W11;
      o_byte = word11[offs[1:0]*8 +: 8];
      o_hit = 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: testbench/sftpr_properties.sv
// Port checker for the timing parameter table slave
`default_nettype none
module sftpr_properties (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  // Write side
  input wire logic I_S_AWVALID,
  input wire logic [sftpr_pkg::ADDR_W-1:0] I_S_AWADDR,
  input wire logic O_S_AWREADY,
  input wire logic I_S_WVALID,
  input wire logic O_S_WREADY,
  input wire logic O_S_BVALID,
  input wire logic [1:0] O_S_BRESP,
  input wire logic I_S_BREADY,
  // Read side
  input wire logic I_S_ARVALID,
  input wire logic [sftpr_pkg::ADDR_W-1:0] I_S_ARADDR,
  input wire logic O_S_ARREADY,
  input wire logic O_S_RVALID,
  input wire logic [sftpr_pkg::DATA_W-1:0] O_S_RDATA,
  input wire logic [1:0] O_S_RRESP,
  input wire logic I_S_RREADY
);
  // ----------------------------------------------------------------
  // Handshake helpers
  // ----------------------------------------------------------------
  wire ar_hs = I_S_ARVALID && O_S_ARREADY;
  wire wr_hs = I_S_AWVALID && O_S_AWREADY && I_S_WVALID && O_S_WREADY;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);

  property p_rd_answer;
    ar_hs |=> O_S_RVALID && !O_S_ARREADY;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer not given one cycle after address");
  property p_rd_hold;
    O_S_RVALID && !I_S_RREADY |=>
      O_S_RVALID && $stable(O_S_RDATA) && $stable(O_S_RRESP);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read answer changed before it was taken");
  property p_b_hold;
    O_S_BVALID && !I_S_BREADY |=> O_S_BVALID && $stable(O_S_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer changed before it was taken");
  property p_wr_busy;
    O_S_BVALID |-> !O_S_AWREADY && !O_S_WREADY;
  endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("write channels ready while answer pending");
  property p_rd_busy;
    O_S_RVALID |-> !O_S_ARREADY;
  endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("read address ready while answer pending");
  property p_wr_ro;
    wr_hs && (I_S_AWADDR inside {8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0,
      8'ha4, 8'ha8}) |=> O_S_BVALID && O_S_BRESP == 2'h2;
  endproperty
  a_wr_ro: assert property (p_wr_ro)
    else $error("table write not refused");
  property p_b24;
    ar_hs && I_S_ARADDR == 8'h90 |=> O_S_RDATA == 32'h00000021;
  endproperty
  a_b24: assert property (p_b24)
    else $error("byte 24h wrong");
  property p_b27;
    ar_hs && I_S_ARADDR == 8'h9c |=> O_S_RDATA == 32'h000000fe;
  endproperty
  a_b27: assert property (p_b27)
    else $error("byte 27h wrong");
  property p_b28;
    ar_hs && I_S_ARADDR == 8'ha0 |=> O_S_RDATA == 32'h00000081;
  endproperty
  a_b28: assert property (p_b28)
    else $error("byte 28h wrong");
  property p_b29;
    ar_hs && I_S_ARADDR == 8'ha4 |=> O_S_RDATA == 32'h000000e4;
  endproperty
  a_b29: assert property (p_b29)
    else $error("byte 29h wrong");
  property p_b2a;
    ar_hs && I_S_ARADDR == 8'ha8 |=> O_S_RDATA == 32'h00000029;
  endproperty
  a_b2a: assert property (p_b2a)
    else $error("byte 2Ah wrong");
endmodule

bind sftpr_top sftpr_properties sftpr_properties_inst (.I_REF_CLK,
  .I_RESET_N, .I_S_AWVALID, .I_S_AWADDR, .O_S_AWREADY, .I_S_WVALID,
  .O_S_WREADY, .O_S_BVALID, .O_S_BRESP, .I_S_BREADY, .I_S_ARVALID,
  .I_S_ARADDR, .O_S_ARREADY, .O_S_RVALID, .O_S_RDATA, .O_S_RRESP,
  .I_S_RREADY);
`default_nettype wire

// file: testbench/sftpr_axi_host.sv
// Host model that reads the parameter table over AXI4-Lite
`default_nettype none
module sftpr_axi_host (
  // Clock
  input wire logic i_clk,
  // Requests
  output logic o_awvalid,
  output logic [7:0] o_awaddr,
  output logic o_wvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_bready,
  output logic o_arvalid,
  output logic [7:0] o_araddr,
  output logic o_rready,
  // Answers
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic [1:0] i_bresp,
  input wire logic i_arready,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial
  begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr, o_wstrb} = 20'h00000;
    o_wdata = 32'h00000000;
  end
  // One write; released address and data lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] resp);
    bit done;
    @(posedge i_clk);
    o_awvalid <= 1'b1;
    o_awaddr <= a;
    o_wvalid <= 1'b1;
    o_wdata <= d;
    o_wstrb <= s;
    o_bready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge i_clk);
      if (o_awvalid && i_awready)
      begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (o_wvalid && i_wready)
      begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
      if (i_bvalid)
      begin
        resp = i_bresp;
        o_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // One read at a bus address; table bytes sit at four times their relative place
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] resp);
    bit done;
    @(posedge i_clk);
    o_arvalid <= 1'b1;
    o_araddr <= a;
    o_rready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(posedge i_clk);
      if (o_arvalid && i_arready)
      begin
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
      if (i_rvalid)
      begin
        d = i_rdata;
        resp = i_rresp;
        o_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/sftpr_top_tb_top.sv
// Self-checking bench for the timing parameter table slave
`default_nettype none
module sftpr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] w10;
  logic [23:0] w11;
  logic [7:0] tab [7] = '{8'h21, 8'h5a, 8'hc1, 8'hfe, 8'h81, 8'he4, 8'h29};
  int mismatches = 0;
  int compares = 0;

  // ----------------------------------------------------------------
  // Clock, reset, design and host
  // ----------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;
  sftpr_top sftpr_top_inst (.I_REF_CLK(ref_clk), .I_RESET_N(reset_n),
    .I_S_AWVALID(awvalid), .I_S_AWADDR(awaddr), .I_S_AWPROT(3'h0),
    .O_S_AWREADY(awready), .I_S_WVALID(wvalid), .I_S_WDATA(wdata),
    .I_S_WSTRB(wstrb), .O_S_WREADY(wready), .O_S_BVALID(bvalid),
    .O_S_BRESP(bresp), .I_S_BREADY(bready), .I_S_ARVALID(arvalid),
    .I_S_ARADDR(araddr), .I_S_ARPROT(3'h0), .O_S_ARREADY(arready),
    .O_S_RVALID(rvalid), .O_S_RDATA(rdata), .O_S_RRESP(rresp),
    .I_S_RREADY(rready));
  sftpr_axi_host sftpr_axi_host_inst (.i_clk(ref_clk),
    .o_awvalid(awvalid), .o_awaddr(awaddr), .o_wvalid(wvalid),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready),
    .o_arvalid(arvalid), .o_araddr(araddr), .o_rready(rready),
    .i_awready(awready), .i_wready(wready), .i_bvalid(bvalid),
    .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid),
    .i_rdata(rdata), .i_rresp(rresp));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    repeat (4000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Direct reads of both words, upper bits zero, answer OKAY
    for (int i = 0; i < 7; i++)
    begin
      sftpr_axi_host_inst.rd(8'h90 + 8'(4 * i), v, rsp);
      check({v[31:8], rsp}, 32'h0);
      if (i < 4)
        w10[8*i+:8] = v[7:0];
      else
        w11[8*(i-4)+:8] = v[7:0];
    end
    check(w10[22:18], 32'h10);
    check(w10[17:16], 32'h1);
    check(w10[15:11], 32'h0b);
    check(w10[10:9], 32'h1);
    check(w10[8:4], 32'h02);
    check(w10[3:0], 32'h1);
    check(w10, 32'hfec15a21);
    check(w11[23], 32'h0);
    check(w11[22:19], 32'h5);
    check(w11[18], 32'h0);
    check(w11[17:14], 32'h7);
    check(w11[13], 32'h1);
    check(w11[12:8], 32'h04);
    check(w11[7:4], 32'h8);
    check(w11[3:0], 32'h1);
    check(w11, 32'h0029e481);
    // Table write refused, byte unchanged
    sftpr_axi_host_inst.wr(8'ha4, 32'h0, 4'hf, rsp);
    check(rsp, sftpr_pkg::RESP_SLVERR);
    sftpr_axi_host_inst.rd(8'ha4, v, rsp);
    check(v, 32'he4);
    // Streamed reads through the pointer, then one past the end
    sftpr_axi_host_inst.wr(sftpr_pkg::ADDR_PTR, 32'h24, 4'hf, rsp);
    check(rsp, sftpr_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      sftpr_axi_host_inst.rd(sftpr_pkg::ADDR_DATA, v, rsp);
      check(v, (i < 7) ? {24'h0, tab[i]} : 32'h0);
    end
    sftpr_axi_host_inst.rd(sftpr_pkg::ADDR_STAT, v, rsp);
    check(v, 32'h00010001);
    // Pointer write with lane 0 off is ignored
    sftpr_axi_host_inst.wr(sftpr_pkg::ADDR_PTR, 32'h26, 4'he, rsp);
    check(rsp, sftpr_pkg::RESP_OKAY);
    sftpr_axi_host_inst.rd(sftpr_pkg::ADDR_PTR, v, rsp);
    check(v, 32'h2c);
    // Write to the data window, a misaligned write and a read of a hole
    sftpr_axi_host_inst.wr(sftpr_pkg::ADDR_DATA, 32'h5, 4'hf, rsp);
    check(rsp, sftpr_pkg::RESP_SLVERR);
    sftpr_axi_host_inst.wr(8'h91, 32'h5, 4'hf, rsp);
    check(rsp, sftpr_pkg::RESP_DECERR);
    sftpr_axi_host_inst.rd(8'hfc, v, rsp);
    check(v, 32'h0);
    check(rsp, sftpr_pkg::RESP_DECERR);
    give_verdict();
  end
endmodule
`default_nettype wire
